// File: dv/i2c_host_model.sv
// Bus controller model: makes the serial clock within frames and drives data open-drain
module i2c_host_model (
   output logic scl, // Serial clock, held high between frames
   output logic sdaDrv, // Data drive, 1 releases the wire to its pull-up
   input wire logic sdaLine // Resolved data wire level
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF = 80;
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end
   // Pulses with data released, so the link side sees its reset
   task automatic idle_clocks(input int n);
      repeat (n) begin
         #HALF scl = 1'b0;
         #HALF scl = 1'b1;
      end
   endtask
   // Odd offset keeps frames out of phase with the system clock
   task automatic start_cond();
      #(HALF+3) sdaDrv = 1'b0;
      #HALF scl = 1'b0;
   endtask
   task automatic stop_cond();
      #(HALF/2) sdaDrv = 1'b0;
      #(HALF/2) scl = 1'b1;
      #HALF sdaDrv = 1'b1;
      #HALF;
   endtask
   // Data set mid-low; line sampled late in the high phase after target lag
   task automatic clock_bit(input logic b, output logic seen);
      #(HALF/2) sdaDrv = b;
      #(HALF/2) scl = 1'b1;
      #(HALF-10) seen = sdaLine;
      #10 scl = 1'b0;
   endtask
   task automatic send_bits(input logic [7:0] d, input int n);
      logic s;
      for (int i = 7; i > 7 - n; i--) begin
         clock_bit(d[i], s);
      end
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      send_bits(d, 8);
      clock_bit(1'b1, ack);
   endtask
   // Acknowledge only when one more status byte is wanted
   task automatic recv_byte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(1'b1, d[i]);
      end
      clock_bit(~more, s);
   endtask
endmodule // i2c_host_model

// File: dv/tuner_synth_i2c_control_tb.sv
// Self-checking bench for the synthesizer control target
module tuner_synth_i2c_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] ADDR_W = {tuner_synth_pkg::ADDR_FIXED, 2'b10, 1'b0};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic supplyLow = 1'b0;
   logic pllLocked = 1'b0;
   logic compFreqIn = 1'b0;
   logic xtalClkRun = 1'b1;
   logic scl, sdaDrv, sdaOut, sdaOe, portOut, portOe, supplyDropFlag, lockIndicator, ack;
   logic pumpSink, pumpSource, pumpDisable, synthEnable, crystalCopyOe;
   logic [14:0] divRatio;
   logic [1:0] pumpCurrentSelect;
   logic [4:0] refRatioSelect;
   logic [8:0] refRatio;
   logic [2:0] mixerPowerSelect;
   logic [7:0] rd;
   logic [7:0] ctl [6] = '{8'h20, 8'h40, 8'h60, 8'hA3, 8'h01, 8'h20};
   logic [6:0] mode [6] = '{7'h40, 7'h20, 7'h18, 7'h47, 7'h0E, 7'h08};
   logic [4:0] code [4] = '{5'h00, 5'h10, 5'h1F, 5'h07};
   logic [8:0] ratio [4] = '{9'h002, 9'h000, 9'h1C0, 9'h100};
   int fails = 0;
   int n_tests = 0;
   int cycles = 0;
   wire sdaLine = sdaDrv & ~sdaOe;
   always #10 clk = ~clk;
   i2c_host_model u_host (.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine));
   tuner_synth_i2c_control u_dut (.clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelHigh(1'b1), .addrSelLow(1'b0),
      .supplyLow(supplyLow), .pllLocked(pllLocked), .xtalClkRun(xtalClkRun), .loClkRun(1'b1),
      .dividerOut(1'b0), .compFreqIn(compFreqIn), .divRatio(divRatio),
      .pumpCurrentSelect(pumpCurrentSelect), .refRatioSelect(refRatioSelect),
      .refRatio(refRatio), .pumpSink(pumpSink), .pumpSource(pumpSource),
      .pumpDisable(pumpDisable), .mixerPowerSelect(mixerPowerSelect),
      .synthEnable(synthEnable), .crystalCopyOe(crystalCopyOe), .portOut(portOut),
      .portOe(portOe), .supplyDropFlag(supplyDropFlag), .lockIndicator(lockIndicator));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic put(input logic [7:0] b, input logic expAck);
      u_host.send_byte(b, ack);
      check("ack", 16'(ack), 16'(expAck));
   endtask
   task automatic open_write();
      u_host.start_cond();
      put(ADDR_W, 1'b0);
   endtask
   task automatic close_frame();
      u_host.stop_cond();
      wait_clk(12);
   endtask
   // Hang guard: whole run needs well under this many cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      fork
         u_host.idle_clocks(3);
         wait_clk(20);
      join
      wait_clk(1);
      rst_n <= 1'b1;
      // Link side leaves reset only on serial clock edges
      fork
         u_host.idle_clocks(3);
         wait_clk(40);
      join
      check("divRatio", 16'(divRatio), 16'h0000);
      check("refRatio", 16'(refRatio), 16'h0002);
      check("ctrl1", 16'({pumpCurrentSelect, refRatioSelect}), 16'h0000);
      check("mixer", 16'(mixerPowerSelect), 16'h0000);
      check("enables", 16'({crystalCopyOe, portOe, synthEnable}), 16'h0005);
      check("dropFlag", 16'(supplyDropFlag), 16'h0001);
      $display("test reset done");
      pllLocked <= 1'b1;
      wait_clk(20);
      u_host.start_cond();
      put(ADDR_W | 8'h01, 1'b0);
      u_host.recv_byte(1'b1, rd);
      check("status", 16'(rd), 16'h00C0);
      u_host.recv_byte(1'b0, rd);
      check("status", 16'(rd), 16'h00C0);
      // Device must stay off the wire after the missing acknowledge
      u_host.recv_byte(1'b0, rd);
      check("afterNack", 16'(rd), 16'h00FF);
      close_frame();
      check("dropFlag", 16'(supplyDropFlag), 16'h0000);
      $display("test read done");
      open_write();
      put(8'h05, 1'b0);
      put(8'hA0, 1'b0);
      put(8'hC9, 1'b0);
      put(8'h17, 1'b0);
      close_frame();
      check("divRatio", 16'(divRatio), 16'h05A0);
      check("pump", 16'(pumpCurrentSelect), 16'h0002);
      check("refRatio", 16'(refRatio), 16'h0005);
      check("mixer", 16'(mixerPowerSelect), 16'h0005);
      check("outs", 16'({crystalCopyOe, portOe, portOut}), 16'h0007);
      $display("test pairs done");
      open_write();
      put(8'h12, 1'b0);
      close_frame();
      check("divRatio", 16'(divRatio), 16'h12A0);
      open_write();
      u_host.send_bits(8'h3F, 4);
      close_frame();
      check("divRatio", 16'(divRatio), 16'h12A0);
      u_host.start_cond();
      put(8'hC0, 1'b1);
      put(8'h00, 1'b1);
      close_frame();
      check("divRatio", 16'(divRatio), 16'h12A0);
      $display("test partial done");
      for (int i = 0; i < 4; i++) begin
         open_write();
         put({3'b100, code[i]}, 1'b0);
         close_frame();
         check("refRatio", 16'(refRatio), 16'(ratio[i]));
      end
      $display("test reference done");
      compFreqIn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         xtalClkRun <= (i < 5);
         open_write();
         put(8'h80, 1'b0);
         put(ctl[i], 1'b0);
         close_frame();
         check("mode", 16'({pumpSink, pumpSource, pumpDisable, lockIndicator, portOe, portOut,
            crystalCopyOe}), 16'(mode[i]));
      end
      $display("test modes done");
      supplyLow <= 1'b1;
      wait_clk(10);
      supplyLow <= 1'b0;
      wait_clk(10);
      check("dropFlag", 16'(supplyDropFlag), 16'h0001);
      check("divRatio", 16'(divRatio), 16'h0000);
      check("refRatio", 16'(refRatio), 16'h0002);
      check("ccOe", 16'(crystalCopyOe), 16'h0001);
      $display("test supply done");
      give_verdict();
   end
endmodule // tuner_synth_i2c_control_tb

// File: verilog/bit_sync.sv
// Two-flop synchroniser for a group of independent levels
module bit_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk, // Destination clock
   input wire logic [WIDTH-1:0] d, // Levels from another domain
   output logic [WIDTH-1:0] q // Synchronised levels
);
   logic [WIDTH-1:0] meta_q;

   // First stage is read by the second stage only
   always_ff @(posedge clk) begin
      meta_q <= d;
      q <= meta_q;
   end
endmodule // bit_sync

// File: verilog/tuner_synth_i2c_control.sv
// Two-wire serial target that programs the synthesizer and converter settings

// How it works
// - Address byte bit zero low means write mode, high means read mode.
// - Address is fixed upper part plus two strap bits from the id pin.
// - Target pulls data low in acknowledge slot after matching address and data bytes.
// - Read continues only while controller acknowledges; missing acknowledge ends reading.
// - First byte after address: top bit zero is divider, one is control.
// - Byte after a classified first byte is its partner byte.
// - Further byte pairs follow without readdressing, classified again, until stop.
// - Stop allowed after any byte; partial byte discarded, last full byte kept.
// - Divider ratio updates only after all fifteen bits or at stop.
// - Upper divider byte holds bits 14..8, lower byte bits 7..0, MSB first.
// - First control byte: flag, two pump current bits, five reference ratio bits.
// - Second control byte: test, mixer power, crystal copy enable, port level.
// - Supply drop flag set by supply loss; cleared by stop ending a read.
// - Supply drop returns all programmed settings to power-up values.
// - Lock indicator reports synthesizer phase lock in normal operation.
// - Reference select decodes to ratios 2..448; three codes are illegal.
// - Two pump current bits select four increasing charge pump currents.
// - Three mixer power bits give eight settings; zero is power-up default.
// - Synthesizer stays enabled in every mixer power setting.
// - Test select forces pump and lock indicator, or routes test clocks to port.
// - Pump test modes and forced lock need crystal and oscillator clocks running.
// - General port on when its bit is one or test select routes test clocks to it, high impedance otherwise.
// - Crystal copy output driven when enabled; enabled at power-up.
// - Status byte: supply drop flag, then lock indicator, six zero bits.
// - Test outputs: divider output halved, or reference divider output.
module tuner_synth_i2c_control (
   input wire logic clk, // System clock, 50 MHz
   input wire logic rst_n, // Synchronous reset, power-up
   input wire logic scl, // Serial clock from controller
   input wire logic sdaIn, // Serial data line level
   output logic sdaOut, // Serial data drive value, always low
   output logic sdaOe, // Serial data pull-down enable
   input wire logic addrSelHigh, // Upper address strap from id pin
   input wire logic addrSelLow, // Lower address strap from id pin
   input wire logic supplyLow, // Supply below threshold
   input wire logic pllLocked, // Phase detector lock
   input wire logic xtalClkRun, // Crystal clock present
   input wire logic loClkRun, // Local oscillator clock present
   input wire logic dividerOut, // Programmable divider output
   input wire logic compFreqIn, // Reference divider output
   output logic [14:0] divRatio, // Loop divider ratio
   output logic [1:0] pumpCurrentSelect, // Charge pump current level
   output logic [4:0] refRatioSelect, // Reference ratio code
   output logic [8:0] refRatio, // Decoded reference ratio, 0 if illegal
   output logic pumpSink, // Pump forced to sink
   output logic pumpSource, // Pump forced to source
   output logic pumpDisable, // Pump disabled
   output logic [2:0] mixerPowerSelect, // Mixer power setting
   output logic synthEnable, // Synthesizer enabled
   output logic crystalCopyOe, // Crystal copy output enable
   output logic portOut, // General port level
   output logic portOe, // General port drive enable
   output logic supplyDropFlag, // Supply drop flag
   output logic lockIndicator // Lock indicator as reported
);

   // Link side, clocked by the serial clock
   logic [4:0] linkSync;
   logic linkRstN;
   logic porL;
   logic lockL;
   logic [1:0] strapL;
   tuner_synth_pkg::link_state_type st_q;
   logic [3:0] bitCnt_q;
   logic [6:0] shift_q;
   logic [7:0] tx_q;
   logic sdaHi_q;
   logic first_q;
   logic byteFirst_q;
   logic [7:0] byteData_q;
   logic byteTgl_q;
   logic rdTgl_q;
   logic sdaOe_q;
   logic sdaOut_q;

   bit_sync #(.WIDTH(5)) u_link_sync (
      .clk(scl),
      .d({rst_n, supplyDropFlag, lockIndicator, addrSelHigh, addrSelLow}),
      .q(linkSync)
   );
   assign linkRstN = linkSync[4];
   assign porL = linkSync[3];
   assign lockL = linkSync[2];
   assign strapL = linkSync[1:0];

   wire [7:0] rxByte = {shift_q, sdaHi_q};
   logic startArm_q;
   logic armUsed_q;

   // A start right after a stop has no clock edge in between; only the data edge shows it
   always_ff @(negedge sdaIn) begin
      startArm_q <= scl;
   end
   wire startDet = ~sdaIn & (sdaHi_q | (startArm_q & ~armUsed_q));
   wire addrHit = rxByte[7:3] == tuner_synth_pkg::ADDR_FIXED && rxByte[2:1] == strapL;
   wire isRead = rxByte[0];
   wire byteDone = bitCnt_q == tuner_synth_pkg::BIT_LAST;
   wire ackEnd = bitCnt_q == tuner_synth_pkg::ACK_SLOT;
   wire ctrlAcked = ~sdaHi_q;
   tuner_synth_pkg::status_type statusL;
   assign statusL = '{supplyDropFlag: porL, lockIndicator: lockL, zero: 6'h00};

   // Data is sampled while the clock is high
   always_ff @(posedge scl) begin
      if (!linkRstN) begin
         sdaHi_q <= 1'b1;
      end else begin
         sdaHi_q <= sdaIn;
      end
   end

   // Data falling while the clock stood high is a start
   always_ff @(negedge scl) begin
      if (!linkRstN) begin
         st_q <= tuner_synth_pkg::LINK_IDLE;
         bitCnt_q <= tuner_synth_pkg::BIT_FIRST;
         sdaOe_q <= 1'b0;
         first_q <= 1'b0;
      end else if (startDet) begin
         st_q <= tuner_synth_pkg::LINK_ADDR;
         bitCnt_q <= tuner_synth_pkg::BIT_FIRST;
         sdaOe_q <= 1'b0;
         first_q <= 1'b1;
      end else if (ackEnd) begin
         bitCnt_q <= tuner_synth_pkg::BIT_FIRST;
         if (st_q == tuner_synth_pkg::LINK_READ && ctrlAcked) begin
            sdaOe_q <= ~statusL[tuner_synth_pkg::MSB];
         end else begin
            sdaOe_q <= 1'b0;
            if (st_q == tuner_synth_pkg::LINK_READ) begin
               st_q <= tuner_synth_pkg::LINK_IDLE;
            end
         end
      end else begin
         bitCnt_q <= 4'(bitCnt_q + 4'h1);
         if (byteDone) begin
            case (st_q)
               tuner_synth_pkg::LINK_ADDR: begin
                  sdaOe_q <= addrHit;
                  if (!addrHit) begin
                     st_q <= tuner_synth_pkg::LINK_IDLE;
                  end else if (isRead) begin
                     st_q <= tuner_synth_pkg::LINK_READ;
                  end else begin
                     st_q <= tuner_synth_pkg::LINK_WRITE;
                  end
               end
               tuner_synth_pkg::LINK_WRITE: begin
                  sdaOe_q <= 1'b1;
                  first_q <= 1'b0;
               end
               default: begin
                  sdaOe_q <= 1'b0;
               end
            endcase
         end else if (st_q == tuner_synth_pkg::LINK_READ) begin
            sdaOe_q <= ~tx_q[tuner_synth_pkg::MSB - 1];
         end else begin
            sdaOe_q <= 1'b0;
         end
      end
   end

   // Shift, transmit and hand-off registers
   always_ff @(negedge scl) begin
      if (!linkRstN) begin
         shift_q <= 7'h00;
         tx_q <= 8'h00;
         byteData_q <= 8'h00;
         byteFirst_q <= 1'b0;
         byteTgl_q <= 1'b0;
         rdTgl_q <= 1'b0;
         sdaOut_q <= 1'b0;
         armUsed_q <= 1'b0;
      end else begin
         // Spent once taken; rearmed when data next falls with the clock low
         armUsed_q <= startArm_q & (armUsed_q | startDet);
         shift_q <= rxByte[6:0];
         sdaOut_q <= 1'b0;
         if (ackEnd) begin
            tx_q <= statusL;
         end else begin
            tx_q <= {tx_q[6:0], 1'b0};
         end
         // Only completed bytes are handed over; a cut byte is dropped
         if (!startDet && byteDone && st_q == tuner_synth_pkg::LINK_WRITE) begin
            byteData_q <= rxByte;
            byteFirst_q <= first_q;
            byteTgl_q <= ~byteTgl_q;
         end
         if (!startDet && byteDone && st_q == tuner_synth_pkg::LINK_ADDR && addrHit && isRead) begin
            rdTgl_q <= ~rdTgl_q;
         end
      end
   end

   assign sdaOe = sdaOe_q;
   assign sdaOut = sdaOut_q;

   // System side
   logic [9:0] sysSync;
   logic sclS, sdaS, supplyS, lockS, xtalS, loS, divS, compS, byteTglS, rdTglS;
   bit_sync #(.WIDTH(10)) u_sys_sync (
      .clk(clk),
      .d({scl, sdaIn, supplyLow, pllLocked, xtalClkRun, loClkRun, dividerOut, compFreqIn,
          byteTgl_q, rdTgl_q}),
      .q(sysSync)
   );
   assign {sclS, sdaS, supplyS, lockS, xtalS, loS, divS, compS, byteTglS, rdTglS} = sysSync;

   logic sdaP_q, byteTglP_q, rdTglP_q, divP_q, divHalf_q;
   logic por_q, readSeen_q, expect_q, secondDiv_q, pending_q;
   logic [7:0] divUpper_q;
   logic [14:0] divRatio_q;
   tuner_synth_pkg::ctrl_first_type ctrl1_q;
   tuner_synth_pkg::ctrl_second_type ctrl2_q;
   logic lockInd_q, pumpSink_q, pumpSource_q, pumpOff_q, portOut_q, portOe_q, synthEn_q;
   logic [8:0] refRatio_q;

   wire stopEv = sclS & sdaS & ~sdaP_q;
   wire byteEv = byteTglS ^ byteTglP_q;
   wire rdEv = rdTglS ^ rdTglP_q;
   wire divEdge = divS & ~divP_q;
   wire settingsRst = ~rst_n | supplyS;
   wire pairFirst = byteFirst_q | ~expect_q;
   wire isDivByte = byteData_q[tuner_synth_pkg::MSB] == tuner_synth_pkg::FLAG_DIV;
   wire [14:0] divFull = {divUpper_q[tuner_synth_pkg::DIV_UPPER_BITS-1:0], byteData_q};
   wire [14:0] divAtStop = {divUpper_q[tuner_synth_pkg::DIV_UPPER_BITS-1:0], divRatio_q[7:0]};

   // Test mode decode; forcing needs both clocks present
   wire [1:0] pumpMode = ctrl2_q.testSelect[1:0];
   wire clocksRun = xtalS & loS;
   wire forceLow = clocksRun && (pumpMode == tuner_synth_pkg::PUMP_SINK ||
      pumpMode == tuner_synth_pkg::PUMP_SOURCE);
   wire forceHigh = clocksRun && pumpMode == tuner_synth_pkg::PUMP_OFF;
   wire lockNext = forceHigh | (lockS & ~forceLow);
   wire testPort = ctrl2_q.testSelect[2];
   wire testClk = pumpMode == tuner_synth_pkg::PUMP_NORMAL ? divHalf_q : compS;

   // Reference ratio decode
   wire [1:0] refGroup = ctrl1_q.refRatioSelect[4:3];
   wire [2:0] refExp = ctrl1_q.refRatioSelect[2:0];
   wire refPow = refGroup == tuner_synth_pkg::REF_GROUP_POW;
   wire refBad = !refPow && refExp == tuner_synth_pkg::REF_EXP_ILLEGAL;
   wire [8:0] refMult = refPow ? tuner_synth_pkg::REF_POW_BASE :
      9'(tuner_synth_pkg::REF_MULT_BASE + {7'h00, refGroup});
   wire [2:0] refShift = refPow ? refExp : 3'(refExp - tuner_synth_pkg::REF_EXP_STEP);
   wire [8:0] refNext = refBad ? tuner_synth_pkg::REF_NONE : 9'(refMult << refShift);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sdaP_q <= 1'b1;
         byteTglP_q <= 1'b0;
         rdTglP_q <= 1'b0;
         divP_q <= 1'b0;
      end else begin
         sdaP_q <= sdaS;
         byteTglP_q <= byteTglS;
         rdTglP_q <= rdTglS;
         divP_q <= divS;
      end
   end

   // Set by supply loss wins over the clear at the end of a read
   always_ff @(posedge clk) begin
      if (settingsRst) begin
         por_q <= 1'b1;
      end else if (stopEv && readSeen_q) begin
         por_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         readSeen_q <= 1'b0;
      end else if (rdEv) begin
         readSeen_q <= 1'b1;
      end else if (stopEv) begin
         readSeen_q <= 1'b0;
      end
   end

   // Byte pairing
   always_ff @(posedge clk) begin
      if (settingsRst) begin
         expect_q <= 1'b0;
         secondDiv_q <= 1'b0;
         pending_q <= 1'b0;
         divUpper_q <= tuner_synth_pkg::DIV_UPPER_RESET;
      end else if (byteEv && pairFirst) begin
         expect_q <= 1'b1;
         secondDiv_q <= isDivByte;
         if (isDivByte) begin
            divUpper_q <= byteData_q;
            pending_q <= 1'b1;
         end
      end else if (byteEv) begin
         expect_q <= 1'b0;
         if (secondDiv_q) begin
            pending_q <= 1'b0;
         end
      end else if (stopEv) begin
         expect_q <= 1'b0;
         pending_q <= 1'b0;
      end
   end

   // Ratio moves only as a whole
   always_ff @(posedge clk) begin
      if (settingsRst) begin
         divRatio_q <= tuner_synth_pkg::DIV_RESET;
      end else if (byteEv && !pairFirst && secondDiv_q) begin
         divRatio_q <= divFull;
      end else if (stopEv && pending_q) begin
         divRatio_q <= divAtStop;
      end
   end

   // Control bytes apply once complete
   always_ff @(posedge clk) begin
      if (settingsRst) begin
         ctrl1_q <= tuner_synth_pkg::CTRL1_RESET;
         ctrl2_q <= tuner_synth_pkg::CTRL2_RESET;
      end else if (byteEv && pairFirst && !isDivByte) begin
         ctrl1_q <= byteData_q;
      end else if (byteEv && !pairFirst && !secondDiv_q) begin
         ctrl2_q <= byteData_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         divHalf_q <= 1'b0;
      end else if (divEdge) begin
         divHalf_q <= ~divHalf_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lockInd_q <= 1'b0;
         pumpSink_q <= 1'b0;
         pumpSource_q <= 1'b0;
         pumpOff_q <= 1'b0;
         portOut_q <= 1'b0;
         portOe_q <= 1'b0;
         synthEn_q <= 1'b1;
         refRatio_q <= tuner_synth_pkg::REF_NONE;
      end else begin
         lockInd_q <= lockNext;
         pumpSink_q <= clocksRun && pumpMode == tuner_synth_pkg::PUMP_SINK;
         pumpSource_q <= clocksRun && pumpMode == tuner_synth_pkg::PUMP_SOURCE;
         pumpOff_q <= forceHigh;
         portOut_q <= testPort ? testClk : ctrl2_q.generalOutputPort;
         portOe_q <= testPort | ctrl2_q.generalOutputPort;
         synthEn_q <= 1'b1;
         refRatio_q <= refNext;
      end
   end

   assign divRatio = divRatio_q;
   assign pumpCurrentSelect = ctrl1_q.pumpCurrentSelect;
   assign refRatioSelect = ctrl1_q.refRatioSelect;
   assign refRatio = refRatio_q;
   assign pumpSink = pumpSink_q;
   assign pumpSource = pumpSource_q;
   assign pumpDisable = pumpOff_q;
   assign mixerPowerSelect = ctrl2_q.mixerPowerSelect;
   assign synthEnable = synthEn_q;
   assign crystalCopyOe = ctrl2_q.crystalCopyOutputEnable;
   assign portOut = portOut_q;
   assign portOe = portOe_q;
   assign supplyDropFlag = por_q;
   assign lockIndicator = lockInd_q;

   property p_por_clear;
      @(posedge clk) disable iff (!rst_n)
      (stopEv && readSeen_q && !supplyS) |=> !por_q;
   endproperty
   a_por_clear: assert property (p_por_clear) else $error("flag not cleared by read stop");

   property p_supply_defaults;
      @(posedge clk) disable iff (!rst_n)
      supplyS |=> (por_q && ctrl2_q == tuner_synth_pkg::CTRL2_RESET &&
         divRatio_q == tuner_synth_pkg::DIV_RESET);
   endproperty
   a_supply_defaults: assert property (p_supply_defaults) else $error("settings kept");

   property p_ratio_pair;
      @(posedge clk) disable iff (!rst_n || supplyS)
      (byteEv && !pairFirst && secondDiv_q) |=> divRatio_q == $past(divFull);
   endproperty
   a_ratio_pair: assert property (p_ratio_pair) else $error("ratio not updated");

   property p_ratio_hold;
      @(posedge clk) disable iff (!rst_n || supplyS)
      (byteEv && pairFirst && isDivByte) |=> $stable(divRatio_q);
   endproperty
   a_ratio_hold: assert property (p_ratio_hold) else $error("ratio moved halfway");

   property p_ctrl_first;
      @(posedge clk) disable iff (!rst_n || supplyS)
      (byteEv && pairFirst && !isDivByte) |=> ctrl1_q == $past(byteData_q) && expect_q;
   endproperty
   a_ctrl_first: assert property (p_ctrl_first) else $error("control byte misfiled");

   property p_forced_lock;
      @(posedge clk) disable iff (!rst_n)
      (clocksRun && pumpMode == tuner_synth_pkg::PUMP_OFF) [*2] |-> lockInd_q && pumpOff_q;
   endproperty
   a_forced_lock: assert property (p_forced_lock) else $error("lock not forced high");

   property p_no_clock_no_force;
      @(posedge clk) disable iff (!rst_n)
      !clocksRun |=> !pumpSink_q && !pumpSource_q && !pumpOff_q && lockInd_q == $past(lockS);
   endproperty
   a_no_clock_no_force: assert property (p_no_clock_no_force) else $error("forced w/o clocks");

   property p_ref_max;
      @(posedge clk) disable iff (!rst_n)
      ctrl1_q.refRatioSelect == 5'h1F |=> refRatio_q == 9'h1C0;
   endproperty
   a_ref_max: assert property (p_ref_max) else $error("ratio decode wrong");

   property p_write_ack;
      @(negedge scl) disable iff (!linkRstN)
      (st_q == tuner_synth_pkg::LINK_WRITE && byteDone && !startDet) |=> sdaOe_q ##1 !sdaOe_q;
   endproperty
   a_write_ack: assert property (p_write_ack) else $error("data byte not acknowledged");

   property p_read_nack;
      @(negedge scl) disable iff (!linkRstN)
      (st_q == tuner_synth_pkg::LINK_READ && ackEnd && sdaHi_q && !startDet) |=>
         (st_q == tuner_synth_pkg::LINK_IDLE && !sdaOe_q) [*8];
   endproperty
   a_read_nack: assert property (p_read_nack) else $error("read went on after nack");

endmodule // tuner_synth_i2c_control

// File: verilog/tuner_synth_pkg.sv
// Shared constants, carriers and state types of the tuner synthesizer control block
package tuner_synth_pkg;

   localparam logic [4:0] ADDR_FIXED = 5'h18;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam int MSB = 7;
   localparam int DIV_UPPER_BITS = 7;

   localparam logic FLAG_DIV = 1'b0;
   localparam logic [14:0] DIV_RESET = 15'h0000;
   localparam logic [7:0] DIV_UPPER_RESET = 8'h00;

   localparam logic [1:0] PUMP_SINK = 2'h1;
   localparam logic [1:0] PUMP_SOURCE = 2'h2;
   localparam logic [1:0] PUMP_OFF = 2'h3;
   localparam logic [1:0] PUMP_NORMAL = 2'h0;
   localparam logic [1:0] REF_GROUP_POW = 2'h0;
   localparam logic [2:0] REF_EXP_ILLEGAL = 3'h0;
   localparam logic [2:0] REF_EXP_STEP = 3'h1;
   localparam logic [8:0] REF_POW_BASE = 9'h002;
   localparam logic [8:0] REF_MULT_BASE = 9'h004;
   localparam logic [8:0] REF_NONE = 9'h000;

   typedef struct packed {
      logic flag;
      logic [1:0] pumpCurrentSelect;
      logic [4:0] refRatioSelect;
   } ctrl_first_type;

   typedef struct packed {
      logic [2:0] testSelect;
      logic [2:0] mixerPowerSelect;
      logic crystalCopyOutputEnable;
      logic generalOutputPort;
   } ctrl_second_type;

   typedef struct packed {
      logic supplyDropFlag;
      logic lockIndicator;
      logic [5:0] zero;
   } status_type;

   // Power-up values: mixer power setting zero, crystal copy on, port off
   localparam ctrl_first_type CTRL1_RESET = 8'h80;
   localparam ctrl_second_type CTRL2_RESET = 8'h02;

   typedef enum logic [1:0] {
      LINK_IDLE = 2'h0,
      LINK_ADDR = 2'h1,
      LINK_WRITE = 2'h3,
      LINK_READ = 2'h2
   } link_state_type;

endpackage
